/* File: shared/interp_step_defines.vh */
// Purpose: Constants for the interpolation deceleration and single-step block
// Assumes: 32-bit AHB-Lite register bus, 125 MHz clock
// Notes: Register offsets are byte addresses
`ifndef INTERP_STEP_DEFINES_VH
`define INTERP_STEP_DEFINES_VH

`define OFS_COMMAND 8'h00
`define OFS_MODE 8'h04
`define OFS_DATA_LOW 8'h08
`define OFS_DATA_HIGH 8'h0C
`define OFS_STATUS 8'h10
`define OFS_SEG_OUT 8'h14

`define CMD_DECEL_ON 8'h3B
`define CMD_DECEL_OFF 8'h3C
`define CMD_STEP 8'h3A
`define CMD_SUDDEN_STOP 8'h27
`define CMD_LINEAR2 8'h30
`define CMD_LINEAR3 8'h31
`define CMD_CIRC_CW 8'h32
`define CMD_CIRC_CCW 8'h33
`define CMD_BITPAT 8'h34
`define CMD_SET_DECEL_PT 8'h07
`define CMD_SET_SPEED 8'h05

// Mode register fields
`define MODE_SCURVE_BIT 2
`define MODE_AUTO_DEC_BIT 3
`define MODE_EXT_STEP_BIT 11
`define MODE_CMD_STEP_BIT 12
`define MODE_CONT_BIT 13
`define MODE_RESET 16'h0000

`define CLK_FREQ_HZ 125000000
`define DEFAULT_PERIOD 32'h0001E848

`endif

/* File: rtl/interp_step_edge.v */
// Purpose: Falling-edge detector for the external step input
// Assumes: Input already synchronous to the clock
// Notes: Latency one clock from the fall to the pulse
`timescale 1ns/1ps
`default_nettype none
module interp_step_edge (
    input wire clock_i,
    input wire rst_n_i,
    input wire step_n_i,
    output reg fall_o
);
    reg prev_reg;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b1;
            fall_o <= 1'b0;
        end else begin
            prev_reg <= step_n_i;
            fall_o <= prev_reg & ~step_n_i;
        end
    end
endmodule // interp_step_edge
`default_nettype wire

/* File: rtl/interp_pulse_timer.v */
// Purpose: Pulse-period timer giving rate ticks and single-step high width
// Assumes: Period in clock cycles, at least 2
// Notes: Step pulse stays high half the period, then low until retriggered
`timescale 1ns/1ps
`default_nettype none
module interp_pulse_timer #(
    parameter W = 32
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire run_i,
    input wire step_i,
    input wire [W-1:0] period_i,
    output reg tick_o,
    output reg step_high_o
);
    reg [W-1:0] cnt_reg;
    reg [W-1:0] half_reg;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= {W{1'b0}};
            half_reg <= {W{1'b0}};
            tick_o <= 1'b0;
            step_high_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (step_i) begin
                half_reg <= period_i >> 1;
                step_high_o <= 1'b1;
            end else if (half_reg > {{(W-1){1'b0}}, 1'b1}) begin
                half_reg <= half_reg - {{(W-1){1'b0}}, 1'b1};
            end else begin
                step_high_o <= 1'b0;
            end
            if (!run_i) begin
                cnt_reg <= {W{1'b0}};
            end else if (cnt_reg + {{(W-1){1'b0}}, 1'b1} >= period_i) begin
                cnt_reg <= {W{1'b0}};
                tick_o <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // interp_pulse_timer
`default_nettype wire

/* File: rtl/interp_decel_step.v */
// Purpose: Interpolation deceleration control and single-step pulse release
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: Interpolation arithmetic is reduced to the master-axis pulse count;
//        second and third axes follow the master step when enabled
`timescale 1ns/1ps
`default_nettype none
`include "interp_step_defines.vh"
// How it works
// RQ1: 3Bh enables deceleration, 3Ch disables it
// RQ2: Reset clears deceleration enable
// RQ3: Enable command ignored while driving
// RQ4: Linear interpolation allows trapezoid or S-curve
// RQ5: Linear: automatic or manual decel point
// RQ6: Host computes manual point from largest axis
// RQ7: Circular, bit pattern: manual trapezoid only
// RQ8: Host loads decel point before circular drive
// RQ9: Continuous chain: manual trapezoid only
// RQ10: Host enables decel before final segment
// RQ11: Decelerate when segment count passes point
// RQ12: Host keeps decel within one segment
// RQ13: One pulse per trigger, constant speed
// RQ14: Step pulse high half the period
// RQ15: Outputs low until next trigger
// RQ16: Command step bit enables 3Ah stepping
// RQ17: Host sets initial speed equal drive speed
// RQ18: Host uses over 1000 PPS for 1 ms steps
// RQ19: Interpolation command arms, no pulses yet
// RQ20: Each step outputs pulses until segment done
// RQ21: Host aborts with 27h, wait, then 3Ah
// RQ22: After stop sequence step commands ignored
// RQ23: External step bit enables falling-edge stepping
// RQ24: External step pulses two to five clocks
// RQ25: Step command inert without command mode
module interp_decel_step (
    input wire clock_i,
    input wire arst_n_i,
    input wire hsel_i,
    input wire [7:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    input wire external_step_input_i,
    input wire [2:0] axis_enable_i,
    input wire [31:0] segment_pulses_i,
    output reg [2:0] axis_pulse_o,
    output reg driving_o,
    output reg decelerating_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_RUN = 2'd1;
    localparam ST_ARMED = 2'd2;
    localparam ST_STOPPED = 2'd3;

    reg [1:0] rst_sync_reg;
    wire rst_n;
    reg [1:0] state_reg;
    reg [15:0] mode_reg;
    reg [15:0] data_low_reg;
    reg [15:0] data_high_reg;
    reg decel_en_reg;
    reg [31:0] decel_point_reg;
    reg [31:0] period_reg;
    reg [31:0] seg_count_reg;
    reg [1:0] interp_kind_reg;
    reg in_decel_reg;
    reg scurve_reg;
    reg wr_pend_reg;
    reg [7:0] wr_addr_reg;
    reg step_req_reg;
    wire tick;
    wire step_high;
    wire ext_fall;
    wire [7:0] cmd_code;
    wire cmd_wr;
    wire addr_phase;
    wire seg_done;
    wire ext_mode;
    wire cmd_mode;
    wire step_mode;
    wire chained;
    wire run_pulse;

    // Reset release through two flops; assertion stays asynchronous
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    assign addr_phase = hsel_i & hready_i & htrans_i[1];
    assign cmd_code = hwdata_i[7:0];
    assign cmd_wr = wr_pend_reg & (wr_addr_reg == `OFS_COMMAND);
    assign ext_mode = mode_reg[`MODE_EXT_STEP_BIT];
    assign cmd_mode = mode_reg[`MODE_CMD_STEP_BIT];
    assign step_mode = ext_mode | cmd_mode;
    assign chained = mode_reg[`MODE_CONT_BIT];
    assign seg_done = (seg_count_reg >= segment_pulses_i);

    function is_interp;
        input [7:0] c;
        begin
            is_interp = (c >= `CMD_LINEAR2) && (c <= `CMD_BITPAT);
        end
    endfunction

    // Linear kinds keep automatic and S-curve options; others lose them
    function [1:0] kind_of;
        input [7:0] c;
        begin
            if (c == `CMD_LINEAR2 || c == `CMD_LINEAR3) begin
                kind_of = 2'd0;
            end else begin
                kind_of = 2'd1;
            end
        end
    endfunction

    // Only unchained linear moves may use automatic or S-curve profiles
    function free_profile;
        input [1:0] kind;
        input link;
        begin
            free_profile = (kind == 2'd0) && !link;
        end
    endfunction

    interp_step_edge u_edge (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .step_n_i(external_step_input_i),
        .fall_o(ext_fall)
    );

    // A step trigger is a 3Ah command in command mode or an edge in external mode
    always @* begin
        step_req_reg = 1'b0;
        if (state_reg == ST_ARMED || state_reg == ST_STOPPED) begin
            if (cmd_wr && cmd_code == `CMD_STEP && cmd_mode) begin // RQ16 RQ25
                step_req_reg = 1'b1;
            end
            if (ext_fall && ext_mode) begin // RQ23 RQ24
                step_req_reg = 1'b1;
            end
        end
    end

    assign run_pulse = (state_reg == ST_RUN);

    interp_pulse_timer #(
        .W(32)
    ) u_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .run_i(run_pulse),
        .step_i(step_req_reg && state_reg == ST_ARMED),
        .period_i(period_reg),
        .tick_o(tick),
        .step_high_o(step_high)
    );

    // Bus slave: zero wait states, always OKAY
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            wr_pend_reg <= addr_phase & hwrite_i;
            wr_addr_reg <= haddr_i;
            if (addr_phase && !hwrite_i) begin
                case (haddr_i)
                    `OFS_MODE: hrdata_o <= {16'h0000, mode_reg};
                    `OFS_DATA_LOW: hrdata_o <= {16'h0000, data_low_reg};
                    `OFS_DATA_HIGH: hrdata_o <= {16'h0000, data_high_reg};
                    `OFS_STATUS: hrdata_o <= {25'h0000000, scurve_reg, interp_kind_reg,
                        in_decel_reg, decel_en_reg, state_reg};
                    `OFS_SEG_OUT: hrdata_o <= seg_count_reg;
                    default: hrdata_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Registers, commands and drive sequence
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= `MODE_RESET;
            data_low_reg <= 16'h0000;
            data_high_reg <= 16'h0000;
            decel_en_reg <= 1'b0; // RQ2
            decel_point_reg <= 32'h00000000;
            period_reg <= `DEFAULT_PERIOD;
            seg_count_reg <= 32'h00000000;
            interp_kind_reg <= 2'd0;
            scurve_reg <= 1'b0;
            in_decel_reg <= 1'b0;
            state_reg <= ST_IDLE;
            axis_pulse_o <= 3'b000;
            driving_o <= 1'b0;
            decelerating_o <= 1'b0;
        end else begin
            if (wr_pend_reg && wr_addr_reg == `OFS_MODE) begin
                mode_reg <= hwdata_i[15:0];
            end
            if (wr_pend_reg && wr_addr_reg == `OFS_DATA_LOW) begin
                data_low_reg <= hwdata_i[15:0];
            end
            if (wr_pend_reg && wr_addr_reg == `OFS_DATA_HIGH) begin
                data_high_reg <= hwdata_i[15:0];
            end
            if (cmd_wr) begin
                if (cmd_code == `CMD_DECEL_ON && state_reg == ST_IDLE) begin
                    decel_en_reg <= 1'b1; // RQ1 RQ3
                end
                if (cmd_code == `CMD_DECEL_OFF) begin
                    decel_en_reg <= 1'b0; // RQ1
                end
                if (cmd_code == `CMD_SET_DECEL_PT) begin
                    decel_point_reg <= {data_high_reg, data_low_reg};
                end
                // Constant speed: one period register serves both speeds
                if (cmd_code == `CMD_SET_SPEED && {data_high_reg, data_low_reg} > 32'h1) begin
                    period_reg <= {data_high_reg, data_low_reg};
                end
            end
            case (state_reg)
                ST_IDLE: begin
                    if (cmd_wr && is_interp(cmd_code)) begin
                        interp_kind_reg <= kind_of(cmd_code); // RQ4 RQ7
                        // S-curve choice is latched per segment; the auto-decel and chain bits are read live from mode_reg
                        scurve_reg <= mode_reg[`MODE_SCURVE_BIT] // RQ4 RQ7
                            & free_profile(kind_of(cmd_code), chained); // RQ9
                        seg_count_reg <= 32'h00000000;
                        in_decel_reg <= 1'b0;
                        driving_o <= 1'b1;
                        state_reg <= step_mode ? ST_ARMED : ST_RUN; // RQ19
                    end
                end
                ST_RUN: begin
                    if (tick) begin
                        seg_count_reg <= seg_count_reg + 32'h00000001;
                    end
                    axis_pulse_o <= tick ? axis_enable_i : 3'b000;
                    // Automatic decel only in linear, non-chained mode
                    if (decel_en_reg && !in_decel_reg) begin
                        if (mode_reg[`MODE_AUTO_DEC_BIT]
                            && free_profile(interp_kind_reg, chained)) begin // RQ5 RQ9
                            in_decel_reg <= (segment_pulses_i - seg_count_reg) <= decel_point_reg;
                        end else begin
                            in_decel_reg <= seg_count_reg > decel_point_reg; // RQ11
                        end
                    end
                    decelerating_o <= in_decel_reg;
                    if (cmd_wr && cmd_code == `CMD_SUDDEN_STOP || seg_done) begin
                        state_reg <= ST_IDLE;
                        driving_o <= 1'b0;
                        axis_pulse_o <= 3'b000;
                        decelerating_o <= 1'b0;
                    end
                end
                ST_ARMED: begin
                    // Step pulse high for half the period, then low
                    axis_pulse_o <= step_high ? axis_enable_i : 3'b000; // RQ13 RQ14 RQ15
                    if (step_req_reg) begin
                        seg_count_reg <= seg_count_reg + 32'h00000001; // RQ20
                    end
                    if (cmd_wr && cmd_code == `CMD_SUDDEN_STOP) begin
                        state_reg <= ST_STOPPED;
                    end else if (seg_done && !step_high) begin
                        state_reg <= ST_IDLE;
                        driving_o <= 1'b0;
                    end
                end
                ST_STOPPED: begin
                    axis_pulse_o <= step_high ? axis_enable_i : 3'b000;
                    // One more trigger ends the drive; later ones find us idle
                    if (step_req_reg && !step_high) begin
                        state_reg <= ST_IDLE; // RQ22
                        driving_o <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // interp_decel_step
`default_nettype wire

/* File: dv/interp_decel_step_props.sv */
// Purpose: Port-level checks for interp_decel_step
// Assumes: Step period programmed to eight clocks
// Notes: Bound to the design from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "interp_step_defines.vh"
module interp_decel_step_props (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic external_step_input_i,
    input wire logic [2:0] axis_enable_i,
    input wire logic [2:0] axis_pulse_o,
    input wire logic driving_o,
    input wire logic decelerating_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    logic cmd_wr_q;
    logic rd_unm_q;
    logic ext_q;
    logic mode_wr_q;
    logic step_mode_q;
    logic [2:0] since_reg;
    wire take = hsel_i && hready_i && htrans_i[1];
    wire step_cmd = cmd_wr_q && (hwdata_i[7:0] == `CMD_STEP);
    wire arm_cmd = cmd_wr_q && (hwdata_i[7:0] >= `CMD_LINEAR2) && (hwdata_i[7:0] <= `CMD_BITPAT);
    // Cycles since the last step trigger, saturating so it never wraps to look fresh
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd_wr_q <= 1'b0;
            rd_unm_q <= 1'b0;
            ext_q <= 1'b1;
            mode_wr_q <= 1'b0;
            step_mode_q <= 1'b0;
            since_reg <= 3'h7;
        end else begin
            // Free-running drives give one-clock pulses, so width checks follow the mode
            mode_wr_q <= take && hwrite_i && (haddr_i == `OFS_MODE);
            if (mode_wr_q) begin
                step_mode_q <= hwdata_i[`MODE_EXT_STEP_BIT] | hwdata_i[`MODE_CMD_STEP_BIT];
            end
            cmd_wr_q <= take && hwrite_i && (haddr_i == `OFS_COMMAND);
            rd_unm_q <= take && !hwrite_i && (haddr_i >= 8'h18);
            ext_q <= external_step_input_i;
            if (step_cmd || (ext_q && !external_step_input_i)) begin
                since_reg <= 3'h0;
            end else if (since_reg != 3'h7) begin
                since_reg <= since_reg + 3'h1;
            end
        end
    end
    sequence high_run_s;
        axis_pulse_o[0] [*4];
    endsequence
    sequence back_low_s;
        !axis_pulse_o[0];
    endsequence
    okay_resp_a: assert property (hreadyout_o && !hresp_o)
        else $error("slave not ready or not okay");
    unmapped_read_a: assert property (rd_unm_q |-> hrdata_o == 32'h0)
        else $error("unmapped read not zero");
    pulse_width_a: assert property ($rose(axis_pulse_o[0]) && step_mode_q
        |-> high_run_s ##1 back_low_s)
        else $error("step pulse width wrong");
    pulse_cause_a: assert property ($rose(axis_pulse_o[0]) && step_mode_q
        |-> since_reg <= 3'h5)
        else $error("pulse without recent trigger");
    axis_mask_a: assert property ((axis_pulse_o & ~axis_enable_i) == 3'h0)
        else $error("pulse on disabled axis");
    axes_together_a: assert property ($rose(axis_pulse_o[0]) |-> axis_pulse_o == axis_enable_i)
        else $error("axes not pulsing together");
    decel_drive_a: assert property (decelerating_o |-> driving_o)
        else $error("decelerating while not driving");
    arm_drive_a: assert property (arm_cmd && !driving_o |-> ##[1:2] driving_o)
        else $error("segment not armed");
endmodule // interp_decel_step_props
`default_nettype wire

/* File: dv/host_bus_model.sv */
// Purpose: Host processor model speaking AHB-Lite single word transfers
// Assumes: One slave whose hreadyout is the bus hready
// Notes: A wait that runs out of its bound raises hung for the bench
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic clock_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [7:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    logic hung;
    initial begin
        hung = 1'b0;
        hsel_o = 1'b0;
        haddr_o = 8'h00;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        @(posedge clock_i);
        hsel_o <= 1'b1;
        haddr_o <= a;
        hwrite_o <= wr;
        htrans_o <= 2'h2;
        n = 0;
        do begin @(posedge clock_i); n++; end while (hready_i !== 1'b1 && n < 16);
        if (hready_i !== 1'b1) hung = 1'b1;
        hsel_o <= 1'b0;
        htrans_o <= 2'h0;
        hwdata_o <= wd;
        n = 0;
        do begin @(posedge clock_i); n++; end while (hready_i !== 1'b1 && n < 16);
        if (hready_i !== 1'b1) hung = 1'b1;
        rd = hrdata_i;
    endtask
endmodule // host_bus_model
`default_nettype wire

/* File: dv/tb_interp_decel_step.sv */
// Purpose: Self-checking bench for interp_decel_step
// Assumes: Step period set to eight clocks; axis mask changed only between drives
// Notes: Pulse sampling reads values before the edge updates, adding one cycle
`timescale 1ns/1ps
`default_nettype none
`include "interp_step_defines.vh"
module tb_interp_decel_step;
    logic clock_i;
    logic arst_n_i;
    logic hsel;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic ext_step;
    logic [2:0] axis_en;
    logic [31:0] seg_pulses;
    wire [31:0] hrdata;
    wire hready;
    wire hresp;
    wire [2:0] axis_pulse;
    wire driving;
    wire decel;
    int failures;
    int num_checks;
    interp_decel_step dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .external_step_input_i(ext_step), .axis_enable_i(axis_en),
        .segment_pulses_i(seg_pulses), .axis_pulse_o(axis_pulse), .driving_o(driving),
        .decelerating_o(decel));
    host_bus_model host (.clock_i(clock_i), .hready_i(hready), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata));
    task automatic stop_test;
        if (host.hung) begin
            failures++;
            $display("Error at %0t: bus wait ran out", $time);
        end
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        host.xfer(1'b1, a, d, unused);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        host.xfer(1'b0, a, 32'h0, d);
    endtask
    task automatic cmd(input logic [7:0] c);
        wr(`OFS_COMMAND, {24'h0, c});
    endtask
    // Bounded: a missing pulse shows as lat of 40
    task automatic meas(output int lat, output int wid);
        lat = 0;
        wid = 0;
        while (axis_pulse[0] !== 1'b1 && lat < 40) begin @(posedge clock_i); lat++; end
        while (axis_pulse[0] === 1'b1 && wid < 40) begin @(posedge clock_i); wid++; end
    endtask
    task automatic t_regs;
        logic [31:0] d;
        rd(`OFS_STATUS, d);
        check(d & 32'h4, 32'h0);
        rd(`OFS_MODE, d);
        check(d, {16'h0, `MODE_RESET});
        rd(8'h1C, d);
        check(d, 32'h0);
        cmd(`CMD_DECEL_ON);
        rd(`OFS_STATUS, d);
        check(d & 32'h4, 32'h4);
        cmd(`CMD_DECEL_OFF);
        rd(`OFS_STATUS, d);
        check(d & 32'h4, 32'h0);
    endtask
    task automatic t_cmd_step;
        int lat;
        int wid;
        logic [31:0] d;
        wr(`OFS_DATA_LOW, 32'h8);
        wr(`OFS_DATA_HIGH, 32'h0);
        cmd(`CMD_SET_SPEED);
        wr(`OFS_MODE, 32'h1 << `MODE_CMD_STEP_BIT);
        cmd(`CMD_LINEAR2);
        meas(lat, wid);
        check(32'(lat), 32'd40);
        check({31'h0, driving}, 32'h1);
        cmd(`CMD_DECEL_ON);
        rd(`OFS_STATUS, d);
        check(d & 32'h4, 32'h0);
        for (int i = 0; i < 3; i++) begin
            cmd(`CMD_STEP);
            meas(lat, wid);
            check(32'(wid), 32'd4);
            repeat (6) @(posedge clock_i);
            check({29'h0, axis_pulse}, 32'h0);
        end
        check({31'h0, driving}, 32'h0);
    endtask
    task automatic t_ext_step;
        int lat;
        int wid;
        wr(`OFS_MODE, 32'h1 << `MODE_EXT_STEP_BIT);
        cmd(`CMD_LINEAR3);
        cmd(`CMD_STEP);
        meas(lat, wid);
        check(32'(lat), 32'd40);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock_i);
            ext_step <= 1'b0;
            meas(lat, wid);
            check(32'((lat >= 3) && (lat <= 6)), 32'h1);
            ext_step <= 1'b1;
            repeat (10) @(posedge clock_i);
        end
        check({31'h0, driving}, 32'h0);
    endtask
    task automatic t_stop;
        int lat;
        int wid;
        wr(`OFS_MODE, 32'h1 << `MODE_CMD_STEP_BIT);
        cmd(`CMD_LINEAR2);
        cmd(`CMD_SUDDEN_STOP);
        repeat (12) @(posedge clock_i);
        check({31'h0, driving}, 32'h1);
        cmd(`CMD_STEP);
        repeat (8) @(posedge clock_i);
        check({31'h0, driving}, 32'h0);
        cmd(`CMD_STEP);
        meas(lat, wid);
        check(32'(lat), 32'd40);
    endtask
    // One free-running segment; at is the pulse count when deceleration shows, 99 if never
    task automatic run_seg(input logic [31:0] m, input logic [31:0] pt, input logic en,
                           input logic [7:0] c, output int at, output int pulses);
        wr(`OFS_MODE, m);
        wr(`OFS_DATA_LOW, pt);
        wr(`OFS_DATA_HIGH, 32'h0);
        cmd(`CMD_SET_DECEL_PT);
        cmd(en ? `CMD_DECEL_ON : `CMD_DECEL_OFF);
        cmd(c);
        at = 99;
        pulses = 0;
        for (int i = 0; i < 60; i++) begin
            @(posedge clock_i);
            if (decel === 1'b1 && at == 99) at = pulses;
            if (axis_pulse !== 3'h0) begin
                pulses++;
                check({29'h0, axis_pulse}, 32'h5);
            end
        end
        check({31'h0, driving}, 32'h0);
    endtask
    task automatic t_decel;
        int at;
        int pulses;
        logic [31:0] d;
        axis_en <= 3'h5;
        run_seg(32'h0, 32'h1, 1'b1, `CMD_LINEAR2, at, pulses);
        check(32'(at), 32'd2);
        check(32'(pulses), seg_pulses);
        rd(`OFS_SEG_OUT, d);
        check(d, seg_pulses);
        run_seg(32'hC, 32'h2, 1'b1, `CMD_LINEAR2, at, pulses);
        check(32'(at), 32'd1);
        rd(`OFS_STATUS, d);
        check(d & 32'h40, 32'h40);
        run_seg(32'hC, 32'h2, 1'b1, `CMD_CIRC_CW, at, pulses);
        check(32'(at), 32'd99);
        rd(`OFS_STATUS, d);
        check(d & 32'h40, 32'h0);
        run_seg(32'h200C, 32'h2, 1'b1, `CMD_LINEAR3, at, pulses);
        check(32'(at), 32'd99);
        run_seg(32'h0, 32'h1, 1'b0, `CMD_LINEAR2, at, pulses);
        check(32'(at), 32'd99);
    endtask
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        failures++;
        $display("Error at %0t: run did not finish in time", $time);
        stop_test();
    end
    initial begin
        failures = 0;
        num_checks = 0;
        arst_n_i = 1'b0;
        ext_step = 1'b1;
        axis_en = 3'h7;
        seg_pulses = 32'h3;
        repeat (16) @(posedge clock_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        t_regs();
        t_cmd_step();
        t_ext_step();
        t_stop();
        t_decel();
        stop_test();
    end
endmodule // tb_interp_decel_step
bind interp_decel_step interp_decel_step_props props (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .external_step_input_i(external_step_input_i), .axis_enable_i(axis_enable_i),
    .axis_pulse_o(axis_pulse_o), .driving_o(driving_o), .decelerating_o(decelerating_o));
`default_nettype wire
